// >>> testbench/sps_slave_model.sv
// serial slave model facing the port
`default_nettype none
module sps_slave_model (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic idle_in,
    input wire logic phase_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    task automatic load(input logic [7:0] b);
        sh = b;
        miso_out = b[7];
    endtask
    // refill with inverted bits so a stale line never looks valid
    always @(sck_in) begin
        if ((sck_in !== idle_in) ^ phase_in) begin
            rx_out = {rx_out[6:0], mosi_in};
        end else if (phase_in) begin
            miso_out = sh[7];
            sh = {sh[6:0], ~sh[0]};
        end else begin
            sh = {sh[6:0], ~sh[0]};
            miso_out = sh[7];
        end
    end
endmodule
`default_nettype wire

// >>> testbench/test_sps_port.sv
// self-checking bench for the serial peripheral port
`default_nettype none
module test_sps_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic cyc = 1'h0;
    logic we = 1'h0;
    logic ss_lvl = 1'h1;
    logic mask = 1'h0;
    logic idle = 1'h0;
    logic phase = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, irq, miso, sck_q;
    logic [5:2] pin_out, pin_oe, pin;
    logic [7:0] rx, q;
    int errors = 0;
    int comparisons = 0;
    int run = 0;
    int half = 0;
    // released mosi and clock lines are pulled up; miso comes from the peer, select from ss_lvl
    assign pin[2] = pin_oe[2] ? pin_out[2] : miso;
    assign pin[3] = pin_oe[3] ? pin_out[3] : 1'h1;
    assign pin[4] = pin_oe[4] ? pin_out[4] : 1'h1;
    assign pin[5] = pin_oe[5] ? pin_out[5] : ss_lvl;
    sps_port dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .pd_pin_in(pin), .pd_pin_out(pin_out), .pd_pin_oe_out(pin_oe),
        .cpu_irq_mask_in(mask), .irq_out(irq));
    sps_slave_model peer (.sck_in(pin[4]), .mosi_in(pin[3]), .idle_in(idle),
        .phase_in(phase), .miso_out(miso), .rx_out(rx));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        sck_q <= pin[4];
        run <= (pin[4] !== sck_q) ? 1 : run + 1;
        if (pin[4] !== sck_q) half <= run;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk_in);
        while (ack !== 1'h1) begin
            n++;
            if (n > 20) errors++;
            if (n > 20) results();
            @(posedge clk_in);
        end
        q = rdat[7:0];
        cyc <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'h0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic xfer(input logic [7:0] c, input logic byp, input logic m, input int h);
        int n;
        n = 0;
        mask <= m;
        idle <= c[3];
        phase <= c[2];
        wr(sps_pkg::OFS_OPTION, {5'h00, byp, 2'h0});
        wr(sps_pkg::OFS_CONTROL, c);
        peer.load(8'h5A ^ c);
        wr(sps_pkg::OFS_DATA, c);
        wr(sps_pkg::OFS_DATA, 8'hFF);
        do begin
            bus(1'h0, sps_pkg::OFS_STATUS, 8'h00);
            n++;
        end while (q[7] !== 1'h1 && n < 400);
        rd(sps_pkg::OFS_STATUS, 8'hC0);
        // a poll that never saw done is a failure, not a silent stop
        if (n == 400) begin
            errors++;
            results();
        end
        chk(half[7:0], h[7:0]);
        chk({7'h00, pin[4]}, {7'h00, c[3]});
        chk({7'h00, irq}, {7'h00, c[7] & ~m});
        chk(rx, c);
        chk({4'h0, pin_oe & pin_out & {4{c[5]}}}, 8'h00);
        rd(sps_pkg::OFS_DATA, 8'h5A ^ c);
        rd(sps_pkg::OFS_STATUS, 8'h00);
        $display("transfer %h done", c);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        rd(sps_pkg::OFS_STATUS, 8'h00);
        rd(8'h20, 8'h00);
        xfer(8'hD0, 1'h0, 1'h0, 2);
        xfer(8'h5D, 1'h0, 1'h1, 4);
        xfer(8'hF6, 1'h0, 1'h0, 16);
        xfer(8'hDB, 1'h0, 1'h1, 32);
        xfer(8'hD3, 1'h1, 1'h0, 1);
        mask <= 1'h0;
        wr(sps_pkg::OFS_CONTROL, 8'hD0);
        ss_lvl <= 1'h0;
        bus(1'h0, sps_pkg::OFS_CONTROL, 8'h00);
        rd(sps_pkg::OFS_STATUS, 8'h10);
        chk({7'h00, irq}, 8'h01);
        ss_lvl <= 1'h1;
        wr(sps_pkg::OFS_CONTROL, 8'h00);
        rd(sps_pkg::OFS_STATUS, 8'h00);
        $display("mode fault done");
        wr(sps_pkg::OFS_DIR, 8'h3C);
        wr(sps_pkg::OFS_PORT, 8'h18);
        chk({pin_oe, pin_out}, 8'hF6);
        wr(sps_pkg::OFS_CONTROL, 8'h50);
        chk({4'h0, pin_oe[5], pin_out[5], pin_oe[4], pin_out[4]}, 8'h0A);
        rd(sps_pkg::OFS_STATUS, 8'h00);
        $display("pin sharing done");
        wr(sps_pkg::OFS_CONTROL, 8'hD2);
        sys_rst_in <= 1'h1;
        @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        rd(sps_pkg::OFS_CONTROL, 8'h06);
        $display("reset done");
        results();
    end
endmodule
`default_nettype wire

// >>> verilog/sps_pkg.sv
// shared constants for the serial peripheral port
`default_nettype none
package sps_pkg;
    // register byte addresses on the bus
    localparam int unsigned ADR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_OPTION = 8'h0C;
    localparam logic [7:0] OFS_DIR = 8'h10;
    localparam logic [7:0] OFS_PORT = 8'h14;
    // control register fields
    localparam int unsigned CTL_IRQ_EN = 7;
    localparam int unsigned CTL_PORT_ON = 6;
    localparam int unsigned CTL_OPEN_DRAIN = 5;
    localparam int unsigned CTL_MASTER = 4;
    localparam int unsigned CTL_IDLE_LVL = 3;
    localparam int unsigned CTL_PHASE = 2;
    localparam int unsigned CTL_RATE_HI = 1;
    localparam int unsigned CTL_RATE_LO = 0;
    // status register fields
    localparam int unsigned ST_DONE = 7;
    localparam int unsigned ST_COLLIDE = 6;
    localparam int unsigned ST_FAULT = 4;
    // option register fields
    localparam int unsigned OPT_BYPASS = 2;
    localparam int unsigned OPT_UPPER_LO = 4;
    // port pins, numbered as port bits
    localparam int unsigned PIN_MISO = 2;
    localparam int unsigned PIN_MOSI = 3;
    localparam int unsigned PIN_SCK = 4;
    localparam int unsigned PIN_SEL = 5;
    // reset values
    localparam logic RST_PHASE = 1'b1;
    // e clock runs at the system clock divided by this
    localparam int unsigned CLK_PER_E = 2;
    // serial clock dividers of the e clock per rate code, and bypass
    localparam int unsigned DIV_CODE0 = 2;
    localparam int unsigned DIV_CODE1 = 4;
    localparam int unsigned DIV_CODE2 = 16;
    localparam int unsigned DIV_CODE3 = 32;
    localparam int unsigned DIV_BYPASS = 1;
    localparam int unsigned HALF_W = 6;
    localparam int unsigned BITS_PER_CHAR = 8;
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_MASTER = 2'b01,
        SPS_SLAVE = 2'b10
    } sps_state_t;
endpackage
`default_nettype wire

// >>> verilog/sps_port.sv
// serial peripheral port with wishbone register access
//
// The address map and the Wishbone register port are this design's own decisions.
`default_nettype none
// How it works
// [RL1] irq_out asks for service on done or fault when enabled and cpu unmasked
// [RL2] port_on_bit gives port pins 5..2 to the serial port
// [RL3] master with direction bit 5 set turns pin 5 into a plain output
// [RL4] open_drain_select makes the four pins drive low only
// [RL5] master_select one drives the serial clock, zero makes a slave
// [RL6] master idles the serial clock at clock_idle_level
// [RL7] clock_edge_phase with idle level picks the clock-to-data relation
// [RL8] rate codes divide the e clock by 2, 4, 16, 32
// [RL9] slave ignores rate codes and follows the external clock
// [RL10] rate_divider_bypass runs the master clock at the e clock
// [RL11] an external master may clock a slave up to the e clock
// [RL12] done flag sets per transfer, cleared by status read then data access
// [RL13] collision flag sets on data write while busy, cleared likewise
// [RL14] select low in master mode sets fault, stops; cleared by status read then control write
// [RL15] status bits 5 and 3..0 read zero and ignore writes
// [RL16] received byte is double buffered, transmit singly buffered
// [RL17] reset clears control except phase set and rate codes kept
// [RL18] eight bits, msb first, exchanged both ways at once
// [RL19] phase clear samples first edge; phase set shifts first, samples second
module sps_port (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [sps_pkg::ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [5:2] pd_pin_in,
    output logic [5:2] pd_pin_out,
    output logic [5:2] pd_pin_oe_out,
    input wire logic cpu_irq_mask_in,
    output logic irq_out
);
    // control, option and port state
    logic irq_en_r;
    logic port_on_r;
    logic open_drain_r;
    logic master_r;
    logic idle_lvl_r;
    logic phase_r;
    logic [1:0] rate_sel_r;
    logic bypass_r;
    logic [3:0] opt_upper_r;
    logic [5:2] dir_r;
    logic [5:2] gp_r;
    // flags and their clear arming
    logic done_r;
    logic coll_r;
    logic fault_r;
    logic done_arm_r;
    logic coll_arm_r;
    logic fault_arm_r;
    // shift engine
    sps_pkg::sps_state_t state_r;
    logic [7:0] sh_r;
    logic [7:0] rx_buf_r;
    logic in_bit_r;
    logic out_bit_r;
    logic [2:0] bit_cnt_r;
    logic sck_r;
    logic sck_prev_r;
    // bus
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;

    logic acc;
    logic wr_any;
    logic rd_any;
    logic wr_ctl;
    logic wr_data;
    logic rd_stat;
    logic acc_data;
    logic ss_low;
    logic ss_is_gp;
    logic fault_evt;
    logic busy;
    logic abort;
    logic tick_m;
    logic lead;
    logic trail;
    logic last_bit;
    logic done_pulse;
    logic ser_in;
    logic ser_out;
    logic [sps_pkg::HALF_W-1:0] half;
    logic [5:2] drv;
    logic [5:2] val;

    function automatic logic adr_is(input logic [sps_pkg::ADR_W-1:0] a,
                                    input logic [7:0] ofs);
        adr_is = (a == ofs);
    endfunction

    function automatic logic [sps_pkg::HALF_W-1:0] half_of(input int unsigned div);
        half_of = sps_pkg::HALF_W'(div * sps_pkg::CLK_PER_E / 2);
    endfunction

    // bus decode; one wait state, ack follows the accepted cycle
    assign acc = wb_cyc_in && wb_stb_in && !ack_r;
    assign wr_any = acc && wb_we_in && wb_sel_in[0];
    assign rd_any = acc && !wb_we_in;
    assign wr_ctl = wr_any && adr_is(wb_adr_in, sps_pkg::OFS_CONTROL);
    assign wr_data = wr_any && adr_is(wb_adr_in, sps_pkg::OFS_DATA);
    assign rd_stat = rd_any && adr_is(wb_adr_in, sps_pkg::OFS_STATUS);
    assign acc_data = (wr_data || rd_any) && adr_is(wb_adr_in, sps_pkg::OFS_DATA);

    // select pin role
    assign ss_is_gp = master_r && dir_r[sps_pkg::PIN_SEL]; // see [RL3]
    assign ss_low = !pd_pin_in[sps_pkg::PIN_SEL];
    assign fault_evt = port_on_r && master_r && !ss_is_gp && ss_low; // see [RL14]

    // rate choice; slave never runs the divider
    always_comb begin
        half = half_of(sps_pkg::DIV_CODE0);
        if (bypass_r) begin
            half = half_of(sps_pkg::DIV_BYPASS); // see [RL10]
        end else begin
            unique case (rate_sel_r) // see [RL8]
                2'b00: half = half_of(sps_pkg::DIV_CODE0);
                2'b01: half = half_of(sps_pkg::DIV_CODE1);
                2'b10: half = half_of(sps_pkg::DIV_CODE2);
                2'b11: half = half_of(sps_pkg::DIV_CODE3);
            endcase
        end
    end

    sps_rate_gen #(
        .CNT_W(sps_pkg::HALF_W)
    ) u_rate (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(state_r == sps_pkg::SPS_MASTER),
        .half_in(half),
        .tick_out(tick_m)
    );

    // edges: master from its own ticks, slave from the pin
    always_comb begin
        lead = 1'b0;
        trail = 1'b0;
        if (state_r == sps_pkg::SPS_MASTER) begin
            lead = tick_m && (sck_r == idle_lvl_r);
            trail = tick_m && (sck_r != idle_lvl_r);
        end else if (state_r == sps_pkg::SPS_SLAVE) begin // see [RL9]
            lead = (pd_pin_in[sps_pkg::PIN_SCK] != sck_prev_r) && (sck_prev_r == idle_lvl_r);
            trail = (pd_pin_in[sps_pkg::PIN_SCK] != sck_prev_r) && (sck_prev_r != idle_lvl_r);
        end
    end

    assign ser_in = master_r ? pd_pin_in[sps_pkg::PIN_MISO] : pd_pin_in[sps_pkg::PIN_MOSI];
    assign ser_out = phase_r ? out_bit_r : sh_r[7]; // see [RL19]
    assign last_bit = (bit_cnt_r == 3'(sps_pkg::BITS_PER_CHAR - 1));
    // slave with phase clear is busy from select, since the first bit is already out
    assign busy = (state_r == sps_pkg::SPS_MASTER) || ((state_r == sps_pkg::SPS_SLAVE)
                  && (!phase_r || (sck_prev_r != idle_lvl_r) || (bit_cnt_r != 3'h0)));
    assign abort = fault_evt || !port_on_r
                   || ((state_r == sps_pkg::SPS_SLAVE) && (!ss_low || master_r))
                   || ((state_r == sps_pkg::SPS_MASTER) && !master_r);
    assign done_pulse = (state_r != sps_pkg::SPS_IDLE) && trail && last_bit && !abort;

    always_ff @(posedge clk_in) begin
        sck_prev_r <= pd_pin_in[sps_pkg::PIN_SCK];
    end

    // shift engine
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= sps_pkg::SPS_IDLE;
            sh_r <= 8'h00;
            in_bit_r <= 1'b0;
            out_bit_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            sck_r <= 1'b0;
        end else begin
            unique case (state_r)
                sps_pkg::SPS_IDLE: begin
                    sck_r <= idle_lvl_r; // see [RL6]
                    bit_cnt_r <= 3'h0;
                    if (wr_data) begin
                        sh_r <= wb_dat_in[7:0]; // see [RL16]
                        out_bit_r <= wb_dat_in[7];
                    end
                    if (port_on_r && master_r && wr_data && !fault_evt) begin
                        state_r <= sps_pkg::SPS_MASTER; // see [RL5]
                    end else if (port_on_r && !master_r && ss_low) begin
                        state_r <= sps_pkg::SPS_SLAVE;
                    end
                end
                sps_pkg::SPS_MASTER, sps_pkg::SPS_SLAVE: begin
                    if (abort) begin
                        state_r <= sps_pkg::SPS_IDLE;
                        bit_cnt_r <= 3'h0;
                        sck_r <= idle_lvl_r;
                    end else begin
                        if (tick_m) begin
                            sck_r <= ~sck_r;
                        end
                        if (lead) begin // see [RL7]
                            if (phase_r) begin
                                out_bit_r <= sh_r[7];
                            end else begin
                                in_bit_r <= ser_in;
                            end
                        end
                        if (trail) begin // see [RL18]
                            sh_r <= {sh_r[6:0], phase_r ? ser_in : in_bit_r};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (last_bit && state_r == sps_pkg::SPS_MASTER) begin
                                state_r <= sps_pkg::SPS_IDLE;
                            end
                        end else if (wr_data && !busy) begin
                            sh_r <= wb_dat_in[7:0];
                        end
                    end
                end
                default: state_r <= sps_pkg::SPS_IDLE;
            endcase
        end
    end

    // receive holding buffer, loaded only at the end of a byte
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_buf_r <= 8'h00;
        end else if (done_pulse) begin
            rx_buf_r <= {sh_r[6:0], phase_r ? ser_in : in_bit_r}; // see [RL16]
        end
    end

    // control register; fault drops master and port_on over a same-cycle write
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin // see [RL17]
            irq_en_r <= 1'b0;
            port_on_r <= 1'b0;
            open_drain_r <= 1'b0;
            master_r <= 1'b0;
            idle_lvl_r <= 1'b0;
            phase_r <= sps_pkg::RST_PHASE;
        end else begin
            if (wr_ctl) begin
                irq_en_r <= wb_dat_in[sps_pkg::CTL_IRQ_EN];
                port_on_r <= wb_dat_in[sps_pkg::CTL_PORT_ON];
                open_drain_r <= wb_dat_in[sps_pkg::CTL_OPEN_DRAIN];
                master_r <= wb_dat_in[sps_pkg::CTL_MASTER];
                idle_lvl_r <= wb_dat_in[sps_pkg::CTL_IDLE_LVL];
                phase_r <= wb_dat_in[sps_pkg::CTL_PHASE];
            end
            if (fault_evt) begin // see [RL14]
                master_r <= 1'b0;
                port_on_r <= 1'b0;
            end
        end
    end

    // rate codes survive reset on purpose
    always_ff @(posedge clk_in) begin
        if (wr_ctl) begin // see [RL17]
            rate_sel_r <= wb_dat_in[sps_pkg::CTL_RATE_HI:sps_pkg::CTL_RATE_LO];
        end
    end

    // option, direction and port data registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bypass_r <= 1'b0;
            opt_upper_r <= 4'h0;
            dir_r <= 4'h0;
            gp_r <= 4'h0;
        end else begin
            if (wr_any && adr_is(wb_adr_in, sps_pkg::OFS_OPTION)) begin
                bypass_r <= wb_dat_in[sps_pkg::OPT_BYPASS];
                opt_upper_r <= wb_dat_in[sps_pkg::OPT_UPPER_LO +: 4];
            end
            if (wr_any && adr_is(wb_adr_in, sps_pkg::OFS_DIR)) begin
                dir_r <= wb_dat_in[5:2];
            end
            if (wr_any && adr_is(wb_adr_in, sps_pkg::OFS_PORT)) begin
                gp_r <= wb_dat_in[5:2];
            end
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            done_r <= 1'b0;
            coll_r <= 1'b0;
            fault_r <= 1'b0;
            done_arm_r <= 1'b0;
            coll_arm_r <= 1'b0;
            fault_arm_r <= 1'b0;
        end else begin
            if (done_pulse) begin // see [RL12]
                done_r <= 1'b1;
            end else if (done_arm_r && acc_data) begin
                done_r <= 1'b0;
            end
            if (wr_data && busy) begin // see [RL13]
                coll_r <= 1'b1;
            end else if (coll_arm_r && acc_data) begin
                coll_r <= 1'b0;
            end
            if (fault_evt) begin // see [RL14]
                fault_r <= 1'b1;
            end else if (fault_arm_r && wr_ctl) begin
                fault_r <= 1'b0;
            end
            if (rd_stat) begin
                done_arm_r <= done_r;
                coll_arm_r <= coll_r;
            end else if (acc_data) begin
                done_arm_r <= 1'b0;
                coll_arm_r <= 1'b0;
            end
            if (rd_stat) begin
                fault_arm_r <= fault_r;
            end else if (wr_ctl) begin
                fault_arm_r <= 1'b0;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        dat_nxt = 32'h0000_0000;
        if (adr_is(wb_adr_in, sps_pkg::OFS_CONTROL)) begin
            dat_nxt[7:0] = {irq_en_r, port_on_r, open_drain_r, master_r,
                            idle_lvl_r, phase_r, rate_sel_r};
        end else if (adr_is(wb_adr_in, sps_pkg::OFS_STATUS)) begin
            dat_nxt[sps_pkg::ST_DONE] = done_r; // see [RL15]
            dat_nxt[sps_pkg::ST_COLLIDE] = coll_r;
            dat_nxt[sps_pkg::ST_FAULT] = fault_r;
        end else if (adr_is(wb_adr_in, sps_pkg::OFS_DATA)) begin
            dat_nxt[7:0] = rx_buf_r;
        end else if (adr_is(wb_adr_in, sps_pkg::OFS_OPTION)) begin
            dat_nxt[sps_pkg::OPT_UPPER_LO +: 4] = opt_upper_r;
            dat_nxt[sps_pkg::OPT_BYPASS] = bypass_r;
        end else if (adr_is(wb_adr_in, sps_pkg::OFS_DIR)) begin
            dat_nxt[5:2] = dir_r;
        end else if (adr_is(wb_adr_in, sps_pkg::OFS_PORT)) begin
            dat_nxt[5:2] = pd_pin_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            dat_r <= rd_any ? dat_nxt : 32'h0000_0000;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign irq_out = irq_en_r && (done_r || fault_r) && !cpu_irq_mask_in; // see [RL1]

    // pin ownership
    always_comb begin
        drv = dir_r;
        val = gp_r;
        if (port_on_r) begin // see [RL2]
            drv[sps_pkg::PIN_MISO] = !master_r && (state_r == sps_pkg::SPS_SLAVE);
            val[sps_pkg::PIN_MISO] = ser_out;
            drv[sps_pkg::PIN_MOSI] = master_r;
            val[sps_pkg::PIN_MOSI] = ser_out;
            drv[sps_pkg::PIN_SCK] = master_r; // see [RL5]
            val[sps_pkg::PIN_SCK] = sck_r;
            drv[sps_pkg::PIN_SEL] = ss_is_gp; // see [RL3]
        end
    end

    // open drain drives low only and releases for a one
    assign pd_pin_oe_out = open_drain_r ? (drv & ~val) : drv; // see [RL4]
    assign pd_pin_out = open_drain_r ? 4'h0 : val;

    sequence s_start_code0;
        $rose(state_r == sps_pkg::SPS_MASTER) && (rate_sel_r == 2'b00) && !bypass_r;
    endsequence
    sequence s_start_bypass;
        $rose(state_r == sps_pkg::SPS_MASTER) && bypass_r;
    endsequence

    property p_irq_request;
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(done_r) && irq_en_r && !cpu_irq_mask_in |-> irq_out;
    endproperty
    a_irq_request: assert property (p_irq_request) else $error("no irq on done"); // see [RL1]

    property p_idle_level;
        @(posedge clk_in) disable iff (sys_rst_in)
        state_r == sps_pkg::SPS_IDLE && $past(state_r) == sps_pkg::SPS_IDLE
        && $stable(idle_lvl_r) |-> sck_r == idle_lvl_r;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong"); // see [RL6]

    property p_rate_code0;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_start_code0 |-> ##1 $stable(sck_r) ##1 $changed(sck_r);
    endproperty
    a_rate_code0: assert property (p_rate_code0) else $error("code 00 half period off"); // see [RL8]

    property p_rate_bypass;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_start_bypass |-> ##1 $changed(sck_r);
    endproperty
    a_rate_bypass: assert property (p_rate_bypass) else $error("bypass clock slow"); // see [RL10]

    property p_done_flag;
        @(posedge clk_in) disable iff (sys_rst_in)
        done_pulse |=> done_r && $changed(rx_buf_r) or done_r;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag not set"); // see [RL12]

    property p_collision;
        @(posedge clk_in) disable iff (sys_rst_in)
        wr_data && busy |=> coll_r && $stable(state_r);
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // see [RL13]

    property p_fault;
        @(posedge clk_in) disable iff (sys_rst_in)
        fault_evt |=> fault_r && !master_r && !port_on_r && state_r == sps_pkg::SPS_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled"); // see [RL14]

    property p_status_zero;
        @(posedge clk_in) disable iff (sys_rst_in)
        rd_stat |=> wb_ack_out && !wb_dat_out[5] && wb_dat_out[3:0] == 4'h0;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status spare bits set"); // see [RL15]

    property p_slave_pins;
        @(posedge clk_in) disable iff (sys_rst_in)
        port_on_r && !master_r |-> !pd_pin_oe_out[sps_pkg::PIN_SCK]
        && !pd_pin_oe_out[sps_pkg::PIN_MOSI];
    endproperty
    a_slave_pins: assert property (p_slave_pins) else $error("slave drives clock"); // see [RL9]

    property p_rx_hold;
        @(posedge clk_in) disable iff (sys_rst_in)
        state_r != sps_pkg::SPS_IDLE && !done_pulse |=> $stable(rx_buf_r);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx buffer changed mid byte"); // see [RL16]

    property p_reset_ctrl;
        @(posedge clk_in)
        sys_rst_in |=> phase_r && !master_r && !port_on_r && !irq_en_r && !idle_lvl_r;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control reset wrong"); // see [RL17]
endmodule
`default_nettype wire

// >>> verilog/sps_rate_gen.sv
// half-period tick generator for the master serial clock
`default_nettype none
module sps_rate_gen #(
    parameter int unsigned CNT_W = 6
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic [CNT_W-1:0] half_in,
    output logic tick_out
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // reload keeps the first half period full length after a start
    assign cnt_nxt = half_in - {{(CNT_W-1){1'b0}}, 1'b1};
    assign tick_out = run_in && (cnt_r == '0);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !run_in) begin
            cnt_r <= cnt_nxt;
        end else if (tick_out) begin
            cnt_r <= cnt_nxt;
        end else begin
            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    property p_tick_gap;
        @(posedge clk_in) disable iff (sys_rst_in)
        tick_out && half_in > 1 |=> !tick_out;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("rate ticks too close"); // see [RL8]
endmodule
`default_nettype wire
